/* rtl/msk_pkg.sv */
// constants and types shared by the manchester modem core
package msk_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int BAUD_BASE = 1200;
	localparam int SAMPLES_PER_BIT = 8;
	localparam int TX_HALF_STEPS = 124;
	localparam int LOCK_BITS = 3;
	localparam int BYTE_BITS = 8;
	localparam int RAMP_STEPS = 20;
	localparam int SAMPLE_DIV1 = CLK_HZ / (SAMPLES_PER_BIT * BAUD_BASE);
	localparam int SAMPLE_DIV2 = CLK_HZ / (SAMPLES_PER_BIT * BAUD_BASE * 2);
	localparam int SAMPLE_DIV3 = CLK_HZ / (SAMPLES_PER_BIT * BAUD_BASE * 3);
	localparam int SAMPLE_DIV4 = CLK_HZ / (SAMPLES_PER_BIT * BAUD_BASE * 4);
	localparam int STEP_DIV1 = CLK_HZ / (2 * TX_HALF_STEPS * BAUD_BASE);
	localparam int STEP_DIV2 = CLK_HZ / (2 * TX_HALF_STEPS * BAUD_BASE * 2);
	localparam int STEP_DIV3 = CLK_HZ / (2 * TX_HALF_STEPS * BAUD_BASE * 3);
	localparam int STEP_DIV4 = CLK_HZ / (2 * TX_HALF_STEPS * BAUD_BASE * 4);
	localparam logic [7:0] ADDR_DATA = 8'hd1;
	localparam logic [7:0] ADDR_STATUS = 8'hd2;
	localparam logic [7:0] ADDR_CONTROL = 8'hd3;
	localparam int ST_RX_EVENT = 0;
	localparam int ST_TX_EVENT = 1;
	localparam int ST_LOCK = 2;
	localparam int ST_PRE = 3;
	localparam int ST_ERR = 4;
	localparam int ST_FULL = 5;
	localparam int CT_RX_EN = 0;
	localparam int CT_TX_EN = 1;
	localparam int CT_BAUD = 2;
	localparam int CT_NIBBLE = 4;
	localparam logic [7:0] CONTROL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [2:0] DAC_OFF = 3'h7;
	localparam logic [2:0] DAC_IDLE = 3'h4;
	localparam logic [2:0] DAC_LOW = 3'h1;
	localparam logic [2:0] DAC_HIGH = 3'h6;
	localparam logic [11:0] PRE_FIXED = 12'haaa;
	typedef enum logic [1:0] {RX_HUNT, RX_COUNT, RX_LOCKED, RX_DATA} msk_rx_state_t;
endpackage

/* rtl/msk_tx_if.sv */
// transmit hand-off between register front end and waveform generator
`timescale 1ns/1ps
interface msk_tx_if;
	logic step_tick;
	logic enable;
	logic load;
	logic [7:0] data;
	logic taken;
	logic busy;
	logic [2:0] dac_code;
	modport core (output enable, load, data, input step_tick, taken, busy, dac_code);
	modport tx (input step_tick, enable, load, data, output taken, busy, dac_code);
endinterface

/* rtl/msk_tick_gen.sv */
// baud-selected tick divider, used for sample and waveform step rates
`timescale 1ns/1ps
module msk_tick_gen #(
	parameter int DIV0 = 8,
	parameter int DIV1 = 4,
	parameter int DIV2 = 3,
	parameter int DIV3 = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [1:0] sel,
	output logic tick
);
	localparam logic [15:0] LIM0 = 16'(DIV0 - 1);
	localparam logic [15:0] LIM1 = 16'(DIV1 - 1);
	localparam logic [15:0] LIM2 = 16'(DIV2 - 1);
	localparam logic [15:0] LIM3 = 16'(DIV3 - 1);
	logic [15:0] cnt;
	logic [15:0] limit;
	logic wrap;
	assign limit = (sel == 2'h0) ? LIM0 : (sel == 2'h1) ? LIM1 : (sel == 2'h2) ? LIM2 : LIM3;
	// >= so a baud change mid-count cannot overrun
	assign wrap = cnt >= limit;
	always_ff @(posedge clk) begin
		if (rst || !run) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			cnt <= wrap ? 16'h0000 : cnt + 16'h0001;
			tick <= wrap;
		end
	end
	property p_tick_gated;
		@(posedge clk) disable iff (rst) !run |=> !tick;
	endproperty
	a_tick_gated: assert property (p_tick_gated) else $error("tick while stopped");
endmodule

/* rtl/msk_tx_wave.sv */
// transmit holding buffer, manchester encoder and dac waveform generator
`timescale 1ns/1ps
module msk_tx_wave (
	input wire logic clk,
	input wire logic rst,
	msk_tx_if.tx txi
);
	localparam logic [6:0] HALF_LAST = 7'(msk_pkg::TX_HALF_STEPS - 1);
	localparam logic [6:0] RAMP = 7'(msk_pkg::RAMP_STEPS);
	localparam logic [6:0] RAMP_END = 7'(msk_pkg::TX_HALF_STEPS - msk_pkg::RAMP_STEPS);
	logic [7:0] hold;
	logic hold_valid;
	logic [7:0] shreg;
	logic [2:0] bit_idx;
	logic half;
	logic [6:0] step;
	logic prev_bit;
	logic cur;
	logic nxt;
	logic start;
	logic bit_end;
	logic reload;
	logic [2:0] lvl1;
	logic [2:0] lvl2;
	logic [2:0] wave;
	logic [2:0] next_dac;
	assign cur = shreg[7];
	assign reload = hold_valid && txi.enable;
	assign nxt = (bit_idx != 3'h7) ? shreg[6] : (reload ? hold[7] : shreg[7]);
	assign start = !txi.busy && reload;
	assign bit_end = txi.busy && txi.step_tick && (step == HALF_LAST) && half;
	assign lvl1 = cur ? msk_pkg::DAC_LOW : msk_pkg::DAC_HIGH;
	assign lvl2 = cur ? msk_pkg::DAC_HIGH : msk_pkg::DAC_LOW;
	assign wave = !half ? ((prev_bit == cur && step < RAMP) ? msk_pkg::DAC_IDLE : lvl1)
		: ((step < RAMP || (cur == nxt && step >= RAMP_END)) ? msk_pkg::DAC_IDLE : lvl2);
	assign next_dac = txi.busy ? wave : (txi.enable ? msk_pkg::DAC_IDLE : msk_pkg::DAC_OFF);
	always_ff @(posedge clk) begin
		if (rst) begin
			hold <= 8'h00;
			hold_valid <= 1'b0;
		end else begin
			hold <= txi.load ? txi.data : hold;
			hold_valid <= txi.load || (hold_valid && !(start || (bit_end && bit_idx == 3'h7)));
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			txi.busy <= 1'b0;
			shreg <= 8'h00;
			bit_idx <= 3'h0;
			half <= 1'b0;
			step <= 7'h00;
			prev_bit <= 1'b0;
			txi.taken <= 1'b0;
			txi.dac_code <= msk_pkg::DAC_OFF;
		end else begin
			txi.dac_code <= next_dac;
			txi.taken <= start || (bit_end && bit_idx == 3'h7 && reload);
			if (start) begin
				txi.busy <= 1'b1;
				shreg <= hold;
				bit_idx <= 3'h0;
				half <= 1'b0;
				step <= 7'h00;
				// idle before the first bit behaves like a repeated bit, so the first half opens at the idle code
				prev_bit <= hold[7];
			end else if (txi.busy && txi.step_tick) begin
				step <= (step == HALF_LAST) ? 7'h00 : step + 7'h01;
				half <= (step == HALF_LAST) ? !half : half;
				if (bit_end) begin
					prev_bit <= cur;
					bit_idx <= bit_idx + 3'h1;
					shreg <= (bit_idx == 3'h7) ? hold : {shreg[6:0], 1'b0};
					txi.busy <= (bit_idx != 3'h7) || reload;
				end
			end
		end
	end
	property p_dac_off;
		@(posedge clk) disable iff (rst) !txi.enable && !txi.busy |=> txi.dac_code == 3'h7;
	endproperty
	a_dac_off: assert property (p_dac_off) else $error("dac not off");
	property p_half_len;
		@(posedge clk) disable iff (rst)
			txi.busy && txi.step_tick && step == HALF_LAST |=> step == 7'h00 && half != $past(half);
	endproperty
	a_half_len: assert property (p_half_len) else $error("half length wrong");
	property p_msb_first;
		@(posedge clk) disable iff (rst) $rose(txi.busy) |-> shreg == $past(hold) && bit_idx == 3'h0;
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("byte not loaded msb first");
endmodule

/* rtl/msk_modem_core.sv */
// manchester modem core: register port, receiver and transmit hook-up
// Contract
// - three valid manchester bits in a row set lock, then preamble search
// - preamble found flag sets when programmed pattern seen after lock
// - violation after lock before preamble: clear lock, set error, restart
// - after preamble shift bits; every eighth copies byte to buffer, sets full
// - shifting continues while software reads the previous byte
// - violation in data: set error, clear lock and preamble, resync
// - any of four flags setting also sets event flag and interrupt
// - full flag settings spaced eight bit periods apart in stream
// - one is low-to-high mid cell, zero is high-to-low
// - cell without mid-cell level change is an error
// - transmit bit is two halves of 124 steps at baud rate
// - first half from previous and current bit, second from current and next
// - transmitter off drives all ones, idle drives idle code
// - line sampled at eight times baud into eight-stage shift register
// - eight-sample group valid only with mid-cell change, counted toward lock
// - after lock bit timing corrected after each bit
// - baud select picks 1200, 2400, 3600 or 4800
// - last four preamble bits match programmed nibble, rest alternating
// - rx disable clears full, preamble, lock; event clear clears full, error
// - transmit bytes msb first, manchester coded
`timescale 1ns/1ps
module msk_modem_core #(
	parameter int SAMPLE_DIV0 = msk_pkg::SAMPLE_DIV1,
	parameter int SAMPLE_DIV1 = msk_pkg::SAMPLE_DIV2,
	parameter int SAMPLE_DIV2 = msk_pkg::SAMPLE_DIV3,
	parameter int SAMPLE_DIV3 = msk_pkg::SAMPLE_DIV4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic line_in,
	output logic [2:0] dac_code_out,
	output logic modem_rx_interrupt,
	output logic modem_tx_interrupt
);
	localparam logic [1:0] LOCK_LAST = 2'(msk_pkg::LOCK_BITS - 1);
	localparam logic [2:0] BIT_LAST = 3'(msk_pkg::BYTE_BITS - 1);
	localparam logic [3:0] PH_LAST = 4'(msk_pkg::SAMPLES_PER_BIT - 1);
	msk_tx_if txi();
	msk_pkg::msk_rx_state_t state;
	msk_pkg::msk_rx_state_t next_state;
	logic [7:0] ctrl;
	logic [7:0] modem_data_buffer;
	logic receiver_lock_flag;
	logic preamble_found_flag;
	logic manchester_error_flag;
	logic rx_full_flag;
	logic rx_event_flag;
	logic tx_event_flag;
	logic rx_enable;
	logic tx_enable;
	logic [1:0] baud_select;
	logic [3:0] preamble_nibble;
	logic sync1;
	logic sync2;
	logic sync3;
	logic line_lvl;
	logic sample_tick;
	logic [7:0] samples;
	logic [3:0] ph;
	logic [3:0] ph_adj;
	logic [1:0] good_cnt;
	logic [2:0] bit_cnt;
	logic [15:0] pre_sr;
	logic [15:0] next_pre_sr;
	logic [7:0] rx_shift;
	logic [7:0] next_rx_shift;
	logic check;
	logic cell_one;
	logic cell_zero;
	logic cell_valid;
	logic early;
	logic late;
	logic pre_match;
	logic lock_set;
	logic pre_set;
	logic err_set;
	logic full_set;
	logic lock_clr;
	logic pre_clr;
	logic any_set;
	logic data_wr;
	logic st_wr;
	logic ct_wr;
	logic sw_clr;
	logic [7:0] status;
	logic [7:0] rd_mux;
	assign rx_enable = ctrl[msk_pkg::CT_RX_EN];
	assign tx_enable = ctrl[msk_pkg::CT_TX_EN];
	assign baud_select = ctrl[msk_pkg::CT_BAUD +: 2];
	assign preamble_nibble = ctrl[msk_pkg::CT_NIBBLE +: 4];
	assign data_wr = wr && addr == msk_pkg::ADDR_DATA;
	assign st_wr = wr && addr == msk_pkg::ADDR_STATUS;
	assign ct_wr = wr && addr == msk_pkg::ADDR_CONTROL;
	assign sw_clr = st_wr && !wdata[msk_pkg::ST_RX_EVENT];
	assign txi.enable = tx_enable;
	assign txi.load = data_wr;
	assign txi.data = wdata;
	assign dac_code_out = txi.dac_code;
	assign modem_rx_interrupt = rx_event_flag;
	assign modem_tx_interrupt = tx_event_flag;
	// sample rate is eight per bit
	msk_tick_gen #(
		.DIV0(SAMPLE_DIV0),
		.DIV1(SAMPLE_DIV1),
		.DIV2(SAMPLE_DIV2),
		.DIV3(SAMPLE_DIV3)
	) u_sample_tick (
		.clk(clk),
		.rst(rst),
		.run(rx_enable),
		.sel(baud_select),
		.tick(sample_tick)
	);
	msk_tick_gen #(
		.DIV0(msk_pkg::STEP_DIV1),
		.DIV1(msk_pkg::STEP_DIV2),
		.DIV2(msk_pkg::STEP_DIV3),
		.DIV3(msk_pkg::STEP_DIV4)
	) u_step_tick (
		.clk(clk),
		.rst(rst),
		.run(tx_enable || txi.busy),
		.sel(baud_select),
		.tick(txi.step_tick)
	);
	msk_tx_wave u_tx (
		.clk(clk),
		.rst(rst),
		.txi(txi)
	);
	// line input resynchronised, level taken once two stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
			line_lvl <= 1'b0;
		end else begin
			sync1 <= line_in;
			sync2 <= sync1;
			sync3 <= sync2;
			line_lvl <= (sync2 == sync3) ? sync3 : line_lvl;
		end
	end
	always_ff @(posedge clk) begin
		if (rst || !rx_enable) begin
			samples <= 8'h00;
		end else if (sample_tick) begin
			samples <= {samples[6:0], line_lvl};
		end
	end
	assign cell_one = samples[7:5] == 3'h0 && samples[2:0] == 3'h7;
	assign cell_zero = samples[7:5] == 3'h7 && samples[2:0] == 3'h0;
	assign cell_valid = cell_one || cell_zero;
	assign late = samples[5] != samples[4];
	assign early = samples[3] != samples[2];
	// nudge the next cell by one sample
	assign ph_adj = late ? 4'h1 : (early ? 4'hf : 4'h0);
	assign check = sample_tick && ph == PH_LAST;
	assign next_pre_sr = {pre_sr[14:0], cell_one};
	assign next_rx_shift = {rx_shift[6:0], cell_one};
	assign pre_match = next_pre_sr == {msk_pkg::PRE_FIXED, preamble_nibble};
	always_comb begin
		next_state = state;
		lock_set = 1'b0;
		pre_set = 1'b0;
		err_set = 1'b0;
		full_set = 1'b0;
		lock_clr = 1'b0;
		pre_clr = 1'b0;
		unique case (state)
			msk_pkg::RX_HUNT: begin
				if (sample_tick && cell_valid) next_state = msk_pkg::RX_COUNT;
			end
			msk_pkg::RX_COUNT: begin
				if (check && !cell_valid) begin
					next_state = msk_pkg::RX_HUNT;
				end else if (check && good_cnt == LOCK_LAST) begin
					next_state = msk_pkg::RX_LOCKED;
					lock_set = 1'b1;
				end
			end
			msk_pkg::RX_LOCKED: begin
				if (check && !cell_valid) begin
					next_state = msk_pkg::RX_HUNT;
					err_set = 1'b1;
					lock_clr = 1'b1;
				end else if (check && pre_match) begin
					next_state = msk_pkg::RX_DATA;
					pre_set = 1'b1;
				end
			end
			msk_pkg::RX_DATA: begin
				if (check && !cell_valid) begin
					next_state = msk_pkg::RX_HUNT;
					err_set = 1'b1;
					lock_clr = 1'b1;
					pre_clr = 1'b1;
				end else if (check && bit_cnt == BIT_LAST) begin
					full_set = 1'b1;
				end
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst || !rx_enable) begin
			state <= msk_pkg::RX_HUNT;
			ph <= 4'h0;
			good_cnt <= 2'h0;
			bit_cnt <= 3'h0;
			pre_sr <= 16'h0000;
			rx_shift <= 8'h00;
		end else begin
			state <= next_state;
			if (sample_tick) ph <= (state == msk_pkg::RX_HUNT) ? 4'h0 : (check ? ph_adj : ph + 4'h1);
			if (state == msk_pkg::RX_HUNT) good_cnt <= 2'h1;
			else if (check && state == msk_pkg::RX_COUNT) good_cnt <= good_cnt + 2'h1;
			if (state == msk_pkg::RX_HUNT) pre_sr <= 16'h0000;
			else if (check && state == msk_pkg::RX_LOCKED) pre_sr <= next_pre_sr;
			// shifting goes on beside the buffer
			if (state != msk_pkg::RX_DATA) bit_cnt <= 3'h0;
			else if (check && cell_valid) bit_cnt <= bit_cnt + 3'h1;
			if (check && cell_valid && state == msk_pkg::RX_DATA) rx_shift <= next_rx_shift;
		end
	end
	assign any_set = lock_set || pre_set || err_set || full_set;
	assign status = {2'b00, rx_full_flag, manchester_error_flag, preamble_found_flag,
		receiver_lock_flag, tx_event_flag, rx_event_flag};
	assign rd_mux = (addr == msk_pkg::ADDR_DATA) ? modem_data_buffer
		: (addr == msk_pkg::ADDR_STATUS) ? status
		: (addr == msk_pkg::ADDR_CONTROL) ? ctrl : 8'h00;
	// hardware sets always beat a clear landing in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl <= msk_pkg::CONTROL_RST;
			modem_data_buffer <= msk_pkg::DATA_RST;
			receiver_lock_flag <= 1'b0;
			preamble_found_flag <= 1'b0;
			manchester_error_flag <= 1'b0;
			rx_full_flag <= 1'b0;
			rx_event_flag <= 1'b0;
			tx_event_flag <= 1'b0;
			rdata <= 8'h00;
		end else begin
			ctrl <= ct_wr ? wdata : ctrl;
			if (full_set) modem_data_buffer <= next_rx_shift;
			receiver_lock_flag <= lock_set || (receiver_lock_flag && !lock_clr && rx_enable);
			preamble_found_flag <= pre_set || (preamble_found_flag && !pre_clr && rx_enable);
			manchester_error_flag <= err_set || (manchester_error_flag && !sw_clr && rx_enable);
			rx_full_flag <= full_set || (rx_full_flag && !sw_clr && rx_enable);
			rx_event_flag <= any_set || (rx_event_flag && !sw_clr);
			tx_event_flag <= txi.taken || (data_wr ? 1'b0
				: (st_wr ? wdata[msk_pkg::ST_TX_EVENT] : tx_event_flag));
			rdata <= rd ? rd_mux : 8'h00;
		end
	end
	// helper: sample ticks between completed bytes
	logic [9:0] gap_cnt;
	logic gap_seen;
	always_ff @(posedge clk) begin
		if (rst || state != msk_pkg::RX_DATA) begin
			gap_cnt <= 10'h000;
			gap_seen <= 1'b0;
		end else if (full_set) begin
			gap_cnt <= 10'h000;
			gap_seen <= 1'b1;
		end else if (sample_tick) begin
			gap_cnt <= gap_cnt + 10'h001;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_bit_ok;
		check && cell_valid;
	endsequence
	sequence s_bit_bad;
		check && !cell_valid;
	endsequence
	property p_lock;
		state == msk_pkg::RX_COUNT && good_cnt == 2'h2 && rx_enable ##0 s_bit_ok
			|=> receiver_lock_flag && state == msk_pkg::RX_LOCKED;
	endproperty
	a_lock: assert property (p_lock) else $error("lock not taken after three cells");
	property p_preamble;
		state == msk_pkg::RX_LOCKED && rx_enable && pre_match ##0 s_bit_ok |=> preamble_found_flag;
	endproperty
	a_preamble: assert property (p_preamble) else $error("preamble flag missing");
	property p_lock_err;
		state == msk_pkg::RX_LOCKED && rx_enable ##0 s_bit_bad
			|=> !receiver_lock_flag && manchester_error_flag && state == msk_pkg::RX_HUNT;
	endproperty
	a_lock_err: assert property (p_lock_err) else $error("violation before preamble");
	property p_byte;
		full_set && rx_enable |=> rx_full_flag && modem_data_buffer == $past(next_rx_shift);
	endproperty
	a_byte: assert property (p_byte) else $error("byte not copied");
	property p_hold_buf;
		state == msk_pkg::RX_DATA && !full_set |=> $stable(modem_data_buffer);
	endproperty
	a_hold_buf: assert property (p_hold_buf) else $error("buffer changed mid byte");
	property p_data_err;
		state == msk_pkg::RX_DATA && rx_enable ##0 s_bit_bad
			|=> manchester_error_flag && !receiver_lock_flag && !preamble_found_flag;
	endproperty
	a_data_err: assert property (p_data_err) else $error("violation in data");
	property p_event;
		$rose(rx_full_flag) || $rose(manchester_error_flag) || $rose(preamble_found_flag)
			|| $rose(receiver_lock_flag) |-> rx_event_flag;
	endproperty
	a_event: assert property (p_event) else $error("event flag not set");
	property p_spacing;
		full_set && gap_seen |-> gap_cnt >= 10'd56 && gap_cnt <= 10'd72;
	endproperty
	a_spacing: assert property (p_spacing) else $error("byte spacing wrong");
	property p_sw_clear;
		sw_clr && !full_set && !err_set |=> !rx_full_flag && !manchester_error_flag;
	endproperty
	a_sw_clear: assert property (p_sw_clear) else $error("event clear ignored");
endmodule

/* test/msk_line_model.sv */
// behavioural line source feeding manchester cells into the sliced input
`timescale 1ns/1ps
module msk_line_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [47:0] pattern,
	input wire logic [5:0] count,
	input wire logic [5:0] bad_at,
	input wire logic [15:0] half_clks,
	output logic line_out,
	output logic busy
);
	int bit_n;
	logic cur;
	initial begin
		line_out = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (go) begin
				busy <= 1'b1;
				for (bit_n = 0; bit_n < count; bit_n++) begin
					cur = pattern[47 - bit_n];
					line_out <= ~cur;
					repeat (half_clks) @(posedge clk);
					line_out <= (bit_n == bad_at) ? ~cur : cur;
					repeat (half_clks) @(posedge clk);
				end
				// flat inverse level after a frame, never a stale last cell
				line_out <= ~line_out;
				busy <= 1'b0;
			end
		end
	end
endmodule

/* test/tb_top.sv */
// self-checking bench for the manchester modem core
`timescale 1ns/1ps
module tb_top;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} msk_row_t;
	localparam logic [7:0] DAT = msk_pkg::ADDR_DATA;
	localparam logic [7:0] STA = msk_pkg::ADDR_STATUS;
	localparam logic [7:0] CTL = msk_pkg::ADDR_CONTROL;
	localparam int DIV [4] = '{16, 8, 6, 4};
	localparam int TXH = msk_pkg::TX_HALF_STEPS * msk_pkg::STEP_DIV4;
	localparam logic [7:0] TXB = 8'ha5;
	localparam logic [47:0] LEAD = 48'hcccccccccccc;
	logic clk;
	logic rst;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic line_in;
	logic [2:0] dac_code_out;
	logic modem_rx_interrupt;
	logic modem_tx_interrupt;
	logic go;
	logic [47:0] pattern;
	logic [5:0] count;
	logic [5:0] bad_at;
	logic [15:0] half_clks;
	logic busy;
	logic [7:0] rd_val;
	int failures;
	int check_count;
	int t_full;
	int cyc = 0;
	msk_row_t rows [6];

	// short sample dividers keep receive frames brief
	msk_modem_core #(.SAMPLE_DIV0(16), .SAMPLE_DIV1(8), .SAMPLE_DIV2(6), .SAMPLE_DIV3(4))
		i_msk_modem_core (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .line_in(line_in), .dac_code_out(dac_code_out),
		.modem_rx_interrupt(modem_rx_interrupt), .modem_tx_interrupt(modem_tx_interrupt));
	msk_line_model i_msk_line_model (.clk(clk), .go(go), .pattern(pattern), .count(count),
		.bad_at(bad_at), .half_clks(half_clks), .line_out(line_in), .busy(busy));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic give_verdict();
		if (failures == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask
	task automatic chk3(input string n, input logic [2:0] e, input logic [2:0] g);
		check_count++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] a);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 rd_val = rdata;
		@(posedge clk);
	endtask
	task automatic wait_flag(input logic [7:0] mask);
		int n;
		n = 0;
		rd_reg(STA);
		while ((rd_val & mask) === 8'h00 && n < 4000) begin
			rd_reg(STA);
			n++;
		end
		// a flag that never came counts against the run
		if ((rd_val & mask) === 8'h00) failures++;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		if (busy !== 1'b0) failures++;
	endtask
	task automatic send(input logic [47:0] p, input logic [5:0] c, input logic [5:0] b,
		input int baud);
		pattern <= p;
		count <= c;
		bad_at <= b;
		half_clks <= 16'(4 * DIV[baud]);
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		// model raises busy by nba, so let it settle before anyone polls it
		@(posedge clk);
	endtask

	initial begin
		repeat (80000) @(posedge clk);
		failures++;
		give_verdict();
	end

	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		go = 1'b0;
		pattern = '0;
		count = 6'd0;
		bad_at = 6'h3f;
		half_clks = 16'd64;
		failures = 0;
		check_count = 0;
		rows = '{'{CTL, 8'h3c, 8'h3c}, '{STA, 8'h02, 8'h02}, '{STA, 8'hff, 8'h02},
			'{STA, 8'h00, 8'h00}, '{8'hd4, 8'h5a, 8'h00}, '{CTL, 8'h00, 8'h00}};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk3("dac at reset", msk_pkg::DAC_OFF, dac_code_out);
		for (int i = 0; i < 6; i++) begin
			wr_reg(rows[i].a, rows[i].d);
			rd_reg(rows[i].a);
			chk8("register", rows[i].e, rd_val);
		end
		send(LEAD, 6'd8, 6'h3f, 0);
		wait_idle();
		rd_reg(STA);
		chk8("status all off", 8'h00, rd_val);
		for (int b = 0; b < 4; b++) begin
			wr_reg(CTL, {4'h3, 2'(b), 2'b01});
			send(LEAD, 6'd6, 6'h3f, b);
			wait_flag(8'h04);
			chk8("lock", 8'h04, rd_val & 8'h04);
			chk8("rx irq", 8'h01, {7'h00, modem_rx_interrupt});
			wait_idle();
			wr_reg(CTL, 8'h00);
		end
		rd_reg(STA);
		chk8("status disabled", 8'h01, rd_val);
		wr_reg(STA, 8'h00);
		// phase-unique leader, preamble with nibble 3, two bytes, short tail
		wr_reg(CTL, 8'h31);
		send(48'hccaaa3c35ea0, 6'd44, 6'h3f, 0);
		wait_flag(8'h08);
		chk8("lock and preamble", 8'h0c, rd_val & 8'h0c);
		wait_flag(8'h20);
		t_full = cyc;
		rd_reg(DAT);
		chk8("first byte", 8'hc3, rd_val);
		wr_reg(STA, 8'h00);
		wait_flag(8'h20);
		chk8("byte spacing", 8'h01, 8'((cyc - t_full) inside {[890:1160]}));
		rd_reg(DAT);
		chk8("second byte", 8'h5e, rd_val);
		wr_reg(STA, 8'h00);
		wait_idle();
		repeat (400) @(posedge clk);
		rd_reg(STA);
		chk8("data violation", 8'h11, rd_val);
		wr_reg(CTL, 8'h00);
		wr_reg(STA, 8'h00);
		wr_reg(CTL, 8'h31);
		send(LEAD, 6'd8, 6'd5, 0);
		wait_flag(8'h10);
		chk8("early violation", 8'h11, rd_val);
		wait_idle();
		wr_reg(CTL, 8'h00);
		wr_reg(CTL, 8'h0e);
		repeat (4) @(posedge clk);
		chk3("dac idle", msk_pkg::DAC_IDLE, dac_code_out);
		wr_reg(DAT, TXB);
		repeat (TXH / 2) @(posedge clk);
		// byte moved to the shifter, so the holding buffer asks for more
		chk8("tx irq", 8'h01, {7'h00, modem_tx_interrupt});
		// middle of each half of the first three cells
		for (int k = 0; k < 6; k++) begin
			chk3("dac half", (TXB[7 - k / 2] ^ k[0]) ? msk_pkg::DAC_LOW : msk_pkg::DAC_HIGH,
				dac_code_out);
			repeat (TXH) @(posedge clk);
		end
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk3("dac after reset", msk_pkg::DAC_OFF, dac_code_out);
		rd_reg(CTL);
		chk8("control after reset", 8'h00, rd_val);
		give_verdict();
	end
endmodule
